// [rtl/rov_top.v]
// residual overvoltage protection with ahb-lite registers and fault log
`timescale 1ns/1ps
`include "rov_defs.vh"
// Function
// (RULE1) Two stages, low and high, each with own pick-up and delay and definite time.
// (RULE2) A stage starts whenever the residual level exceeds its pick-up; the code does not start a stage while it is blocked.
// (RULE3) A stage trips when its start lasts longer than its operate delay.
// (RULE4) Only the fundamental residual component is compared, third harmonic rejected.
// (RULE5) Phase-derived mode sums the three phase voltages and uses the phase scale.
// (RULE6) Dedicated-input mode takes the residual input and uses its own scale.
// (RULE7) Four setting groups, chosen manually or by a selected digital signal.
// (RULE8) The group signal source is none, digital, virtual, indicator, virtual out or key.
// (RULE9) Each stage counts start and trip events, clearable on request.
// (RULE10) One shared force flag allows forced status and clears after five minutes.
// (RULE11) Each stage reports idle, blocked, started or tripped; start and trip forceable.
// (RULE12) The eight latest faults are kept with date, time, voltage, delay and group.
// (RULE13) The logged delay is percent of the operate delay, 100 meaning trip.
// (RULE14) Level, pick-ups and logged voltage share one percent scale.
// (RULE15) Falling below pick-up before the delay drops start and rearms the timer.
module rov_top #(
	parameter MS_CYCLES = `ROV_MS_CYCLES,
	parameter FORCE_TIMEOUT_MS = `ROV_FORCE_TIMEOUT_MS
) (
	input wire mclk,
	input wire srst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	input wire sampleValid,
	input wire [15:0] sampleA,
	input wire [15:0] sampleB,
	input wire [15:0] sampleC,
	input wire [15:0] sampleRes,
	input wire [7:0] digitalIn,
	input wire [7:0] virtualInputN,
	input wire [7:0] indicatorSignalN,
	input wire [7:0] virtualOutputN,
	input wire [7:0] functionKeyN,
	input wire blockLow,
	input wire blockHigh,
	input wire [31:0] rtcDate,
	input wire [31:0] rtcMsOfDay,
	output wire startLow,
	output wire tripLow,
	output wire startHigh,
	output wire tripHigh,
	output reg forceFlag
);
	reg [31:0] ctrl;
	reg [15:0] scalePhase;
	reg [15:0] scaleRes;
	reg [31:0] setting [0:7];
	reg [2:0] recSel;
	reg [11:0] wrAddr;
	reg wrPend;
	reg [3:0] sampIdx;
	reg signed [31:0] accRe;
	reg signed [31:0] accIm;
	reg [15:0] mag;
	reg [15:0] residualLevel;
	reg [17:0] msDiv;
	reg msTick;
	reg [18:0] forceCnt;
	reg [1:0] activeGroup;
	reg recHighPend;
	reg [15:0] highVoltHold;
	reg [6:0] highPctHold;
	wire [3:0] stateLow;
	wire [3:0] stateHigh;
	wire [15:0] startCntLow;
	wire [15:0] tripCntLow;
	wire [15:0] startCntHigh;
	wire [15:0] tripCntHigh;
	wire recLow;
	wire recHigh;
	wire [15:0] voltLow;
	wire [15:0] voltHigh;
	wire [6:0] pctLow;
	wire [6:0] pctHigh;
	wire [`ROV_REC_W-1:0] recRd;
	wire [3:0] recFill;
	integer i;
	localparam [17:0] MS_LAST = MS_CYCLES[17:0] - 18'h00001;
	localparam [18:0] FORCE_LAST = FORCE_TIMEOUT_MS[18:0];

	function signed [7:0] sinLut;
		input [3:0] idx;
		begin
			case (idx)
				4'h0: sinLut = 8'sd0;
				4'h1: sinLut = 8'sd49;
				4'h2: sinLut = 8'sd90;
				4'h3: sinLut = 8'sd117;
				4'h4: sinLut = 8'sd127;
				4'h5: sinLut = 8'sd117;
				4'h6: sinLut = 8'sd90;
				4'h7: sinLut = 8'sd49;
				4'h8: sinLut = 8'sd0;
				4'h9: sinLut = -8'sd49;
				4'ha: sinLut = -8'sd90;
				4'hb: sinLut = -8'sd117;
				4'hc: sinLut = -8'sd127;
				4'hd: sinLut = -8'sd117;
				4'he: sinLut = -8'sd90;
				default: sinLut = -8'sd49;
			endcase
		end
	endfunction

	function [31:0] absVal;
		input signed [31:0] v;
		begin
			absVal = v[31] ? (~v + 32'h00000001) : v;
		end
	endfunction

	// bus slave, always zero wait, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	wire addrPhase = hsel & hready & htrans[1];
	wire [11:0] busAddr = {haddr[11:2], 2'b00};
	wire isSetting = (busAddr[11:5] == 7'h01);
	wire [2:0] setIdx = busAddr[4:2];
	wire ctrlWrite = wrPend & (wrAddr == `ROV_OFS_CTRL);

	// (RULE5) phase-derived residual
	wire signed [17:0] phaseSum = $signed(sampleA) + $signed(sampleB) + $signed(sampleC);
	wire signed [33:0] phaseThird = phaseSum * $signed(17'sd21845);
	// (RULE6) dedicated residual input
	wire signed [15:0] resSample = ctrl[`ROV_CTRL_MODE] ? phaseThird[31:16] : $signed(sampleRes);
	wire signed [23:0] prodRe = resSample * sinLut(sampIdx + 4'h4);
	wire signed [23:0] prodIm = resSample * sinLut(sampIdx);
	wire [31:0] absRe = absVal(accRe + {{8{prodRe[23]}}, prodRe});
	wire [31:0] absIm = absVal(accIm + {{8{prodIm[23]}}, prodIm});
	wire [31:0] magWide = (absRe > absIm) ? (absRe + {1'b0, absIm[31:1]})
		: (absIm + {1'b0, absRe[31:1]});
	wire [15:0] scaleSel = ctrl[`ROV_CTRL_MODE] ? scalePhase : scaleRes;
	wire [31:0] scaled = mag * scaleSel;

	always @(posedge mclk) begin
		if (srst) begin
			sampIdx <= 4'h0;
			accRe <= 32'sh00000000;
			accIm <= 32'sh00000000;
			mag <= 16'h0000;
			residualLevel <= 16'h0000;
		end else begin
			// (RULE14) common percent scale
			residualLevel <= scaled[31:16];
			// (RULE4) one-cycle fundamental correlation
			if (sampleValid) begin
				sampIdx <= sampIdx + 4'h1;
				if (sampIdx == 4'hf) begin
					accRe <= 32'sh00000000;
					accIm <= 32'sh00000000;
					mag <= (magWide[31:26] != 6'h00) ? 16'hffff : magWide[25:10];
				end else begin
					accRe <= accRe + {{8{prodRe[23]}}, prodRe};
					accIm <= accIm + {{8{prodIm[23]}}, prodIm};
				end
			end
		end
	end

	// (RULE8) group select source
	reg groupSig;
	always @* begin
		case (ctrl[`ROV_CTRL_SRC_LSB +: 3])
			`ROV_SRC_DIGITAL: groupSig = digitalIn[ctrl[`ROV_CTRL_IDX_LSB +: 3]];
			`ROV_SRC_VIRT_IN: groupSig = virtualInputN[ctrl[`ROV_CTRL_IDX_LSB +: 3]];
			`ROV_SRC_INDICATOR: groupSig = indicatorSignalN[ctrl[`ROV_CTRL_IDX_LSB +: 3]];
			`ROV_SRC_VIRT_OUT: groupSig = virtualOutputN[ctrl[`ROV_CTRL_IDX_LSB +: 3]];
			`ROV_SRC_FKEY: groupSig = functionKeyN[ctrl[`ROV_CTRL_IDX_LSB +: 3]];
			default: groupSig = 1'b0;
		endcase
	end

	always @(posedge mclk) begin
		if (srst) begin
			msDiv <= 18'h00000;
			msTick <= 1'b0;
			forceFlag <= 1'b0;
			forceCnt <= 19'h00000;
			activeGroup <= 2'b00;
		end else begin
			msTick <= (msDiv == MS_LAST);
			msDiv <= (msDiv == MS_LAST) ? 18'h00000 : msDiv + 18'h00001;
			// (RULE7) manual or signal group
			activeGroup <= groupSig ? ctrl[`ROV_CTRL_ALTGRP_LSB +: 2] : ctrl[`ROV_CTRL_GRP_LSB +: 2];
			// (RULE10) force flag timeout
			if (ctrlWrite) begin
				forceFlag <= hwdata[`ROV_CTRL_FORCE];
				forceCnt <= 19'h00000;
			end else if (forceFlag && msTick) begin
				if (forceCnt >= FORCE_LAST) begin
					forceFlag <= 1'b0;
					forceCnt <= 19'h00000;
				end else begin
					forceCnt <= forceCnt + 19'h00001;
				end
			end
		end
	end

	always @(posedge mclk) begin
		if (srst) begin
			ctrl <= 32'h00000000;
			scalePhase <= `ROV_RESET_SCALE;
			scaleRes <= `ROV_RESET_SCALE;
			recSel <= 3'h0;
			wrPend <= 1'b0;
			wrAddr <= 12'h000;
			hrdata <= 32'h00000000;
			for (i = 0; i < 8; i = i + 1) begin
				setting[i] <= 32'h00000000;
			end
		end else begin
			wrPend <= addrPhase & hwrite & (hsize == 3'b010);
			if (addrPhase) begin
				wrAddr <= busAddr;
			end
			// clear bits are one-cycle requests
			ctrl[`ROV_CTRL_CLR_LOW] <= 1'b0;
			ctrl[`ROV_CTRL_CLR_HIGH] <= 1'b0;
			if (wrPend) begin
				if (wrAddr == `ROV_OFS_CTRL) begin
					ctrl <= {12'h000, hwdata[19:0]};
				end else if (wrAddr == `ROV_OFS_SCALE_PHASE) begin
					scalePhase <= hwdata[15:0];
				end else if (wrAddr == `ROV_OFS_SCALE_RES) begin
					scaleRes <= hwdata[15:0];
				end else if (wrAddr == `ROV_OFS_REC_SEL) begin
					recSel <= hwdata[2:0];
				end else if (wrAddr[11:5] == 7'h01) begin
					setting[wrAddr[4:2]] <= hwdata;
				end
			end
			if (addrPhase && !hwrite) begin
				if (isSetting) begin
					hrdata <= setting[setIdx];
				end else begin
					case (busAddr)
						`ROV_OFS_CTRL: hrdata <= {12'h000, ctrl[19:2], forceFlag, ctrl[0]};
						`ROV_OFS_SCALE_PHASE: hrdata <= {16'h0000, scalePhase};
						`ROV_OFS_SCALE_RES: hrdata <= {16'h0000, scaleRes};
						`ROV_OFS_STATUS: hrdata <= {6'h00, activeGroup, stateHigh, stateLow,
							residualLevel};
						`ROV_OFS_CNT_LOW: hrdata <= {tripCntLow, startCntLow};
						`ROV_OFS_CNT_HIGH: hrdata <= {tripCntHigh, startCntHigh};
						`ROV_OFS_REC_SEL: hrdata <= {24'h000000, recFill, 1'b0, recSel};
						`ROV_OFS_REC_W0: hrdata <= recRd[31:0];
						`ROV_OFS_REC_W1: hrdata <= recRd[63:32];
						`ROV_OFS_REC_W2: hrdata <= {6'h00, recRd[89:64]};
						default: hrdata <= 32'h00000000;
					endcase
				end
			end
		end
	end

	// (RULE1) low and high stages
	wire [31:0] setLow = setting[{1'b0, activeGroup}];
	wire [31:0] setHigh = setting[{1'b1, activeGroup}];

	rov_stage lowStage (
		.mclk(mclk),
		.srst(srst),
		.level(residualLevel),
		.pickup(setLow[15:0]),
		.delayMs(setLow[31:16]),
		.msTick(msTick),
		.blocked(blockLow),
		.forceEn(forceFlag),
		.forceStart(ctrl[`ROV_CTRL_FSTART_LOW]),
		.forceTrip(ctrl[`ROV_CTRL_FTRIP_LOW]),
		.clrCnt(ctrl[`ROV_CTRL_CLR_LOW]),
		.start(startLow),
		.trip(tripLow),
		.state(stateLow),
		.startEventCount(startCntLow),
		.tripEventCount(tripCntLow),
		.recValid(recLow),
		.recVolt(voltLow),
		.recPct(pctLow)
	);

	rov_stage highStage (
		.mclk(mclk),
		.srst(srst),
		.level(residualLevel),
		.pickup(setHigh[15:0]),
		.delayMs(setHigh[31:16]),
		.msTick(msTick),
		.blocked(blockHigh),
		.forceEn(forceFlag),
		.forceStart(ctrl[`ROV_CTRL_FSTART_HIGH]),
		.forceTrip(ctrl[`ROV_CTRL_FTRIP_HIGH]),
		.clrCnt(ctrl[`ROV_CTRL_CLR_HIGH]),
		.start(startHigh),
		.trip(tripHigh),
		.state(stateHigh),
		.startEventCount(startCntHigh),
		.tripEventCount(tripCntHigh),
		.recValid(recHigh),
		.recVolt(voltHigh),
		.recPct(pctHigh)
	);

	// high record waits a cycle when both end together
	always @(posedge mclk) begin
		if (srst) begin
			recHighPend <= 1'b0;
			highVoltHold <= 16'h0000;
			highPctHold <= 7'h00;
		end else begin
			recHighPend <= recHigh & recLow;
			highVoltHold <= voltHigh;
			highPctHold <= pctHigh;
		end
	end
	wire useLow = recLow;
	wire recWr = recLow | recHigh | recHighPend;
	wire [15:0] wrVolt = useLow ? voltLow : (recHighPend ? highVoltHold : voltHigh);
	wire [6:0] wrPct = useLow ? pctLow : (recHighPend ? highPctHold : pctHigh);
	wire wrStage = ~useLow;
	// (RULE12) latest eight faults
	wire [`ROV_REC_W-1:0] recWord = {wrStage, activeGroup, wrPct, wrVolt, rtcMsOfDay, rtcDate};

	rov_fault_mem #(
		.WIDTH(`ROV_REC_W),
		.DEPTH(`ROV_NUM_RECORDS),
		.AW(3)
	) faultLog (
		.mclk(mclk),
		.srst(srst),
		.wrEn(recWr),
		.wrData(recWord),
		.rdSel(recSel),
		.rdData(recRd),
		.fill(recFill)
	);
endmodule // rov_top

// [rtl/rov_defs.vh]
// constants for the residual overvoltage stages
`ifndef ROV_DEFS_VH
`define ROV_DEFS_VH
`define ROV_CLK_KHZ 250000
`define ROV_MS_CYCLES (`ROV_CLK_KHZ)
`define ROV_FORCE_TIMEOUT_S 300
`define ROV_FORCE_TIMEOUT_MS (`ROV_FORCE_TIMEOUT_S * 1000)
`define ROV_SAMPLES_PER_CYCLE 16
`define ROV_TRIP_PCT 7'd100
`define ROV_NUM_RECORDS 8
`define ROV_REC_W 90
`define ROV_OFS_CTRL 12'h000
`define ROV_OFS_SCALE_PHASE 12'h004
`define ROV_OFS_SCALE_RES 12'h008
`define ROV_OFS_SETTING_BASE 12'h020
`define ROV_OFS_STATUS 12'h040
`define ROV_OFS_CNT_LOW 12'h044
`define ROV_OFS_CNT_HIGH 12'h048
`define ROV_OFS_REC_SEL 12'h080
`define ROV_OFS_REC_W0 12'h084
`define ROV_OFS_REC_W1 12'h088
`define ROV_OFS_REC_W2 12'h08c
`define ROV_CTRL_MODE 0
`define ROV_CTRL_FORCE 1
`define ROV_CTRL_CLR_LOW 2
`define ROV_CTRL_CLR_HIGH 3
`define ROV_CTRL_SRC_LSB 4
`define ROV_CTRL_IDX_LSB 8
`define ROV_CTRL_GRP_LSB 12
`define ROV_CTRL_ALTGRP_LSB 14
`define ROV_CTRL_FSTART_LOW 16
`define ROV_CTRL_FTRIP_LOW 17
`define ROV_CTRL_FSTART_HIGH 18
`define ROV_CTRL_FTRIP_HIGH 19
`define ROV_SRC_NONE 3'd0
`define ROV_SRC_DIGITAL 3'd1
`define ROV_SRC_VIRT_IN 3'd2
`define ROV_SRC_INDICATOR 3'd3
`define ROV_SRC_VIRT_OUT 3'd4
`define ROV_SRC_FKEY 3'd5
`define ROV_RESET_SCALE 16'h0100
`endif

// [rtl/rov_fault_mem.v]
// record store of the latest faults, newest first on read
`timescale 1ns/1ps
module rov_fault_mem #(
	parameter WIDTH = 90,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire mclk,
	input wire srst,
	input wire wrEn,
	input wire [WIDTH-1:0] wrData,
	input wire [AW-1:0] rdSel,
	output reg [WIDTH-1:0] rdData,
	output reg [AW:0] fill
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr;
	wire [AW-1:0] rdAddr = wrPtr - rdSel - {{(AW-1){1'b0}}, 1'b1};
	always @(posedge mclk) begin
		if (wrEn) begin
			mem[wrPtr] <= wrData;
		end
		if (srst) begin
			wrPtr <= {AW{1'b0}};
			fill <= {(AW+1){1'b0}};
			rdData <= {WIDTH{1'b0}};
		end else begin
			if (wrEn) begin
				wrPtr <= wrPtr + {{(AW-1){1'b0}}, 1'b1};
				if (fill != DEPTH) begin
					fill <= fill + {{AW{1'b0}}, 1'b1};
				end
			end
			rdData <= ({1'b0, rdSel} < fill) ? mem[rdAddr] : {WIDTH{1'b0}};
		end
	end
endmodule // rov_fault_mem

// [rtl/rov_stage.v]
// one definite-time residual overvoltage stage
`timescale 1ns/1ps
`include "rov_defs.vh"
module rov_stage (
	input wire mclk,
	input wire srst,
	input wire [15:0] level,
	input wire [15:0] pickup,
	input wire [15:0] delayMs,
	input wire msTick,
	input wire blocked,
	input wire forceEn,
	input wire forceStart,
	input wire forceTrip,
	input wire clrCnt,
	output wire start,
	output wire trip,
	output reg [3:0] state,
	output reg [15:0] startEventCount,
	output reg [15:0] tripEventCount,
	output reg recValid,
	output reg [15:0] recVolt,
	output reg [6:0] recPct
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_BLOCKED = 4'b0010;
	localparam ST_STARTED = 4'b0100;
	localparam ST_TRIPPED = 4'b1000;
	reg [15:0] elapsed;
	reg [15:0] peak;
	wire pick = (level > pickup) | (forceEn & (forceStart | forceTrip));
	wire fTrip = forceEn & forceTrip;
	wire [22:0] pctWide = (elapsed * 7'd100) / ((delayMs == 16'h0000) ? 16'h0001 : delayMs);
	wire [6:0] pctNow = (pctWide > 23'd100) ? `ROV_TRIP_PCT : pctWide[6:0];
	wire incStart = (state == ST_IDLE) & pick & ~blocked;
	wire incTrip = (state == ST_STARTED) & ~blocked & pick & (fTrip | (elapsed > delayMs));
	assign start = state[2] | state[3];
	assign trip = state[3];
	always @(posedge mclk) begin
		if (srst) begin
			state <= ST_IDLE;
			elapsed <= 16'h0000;
			peak <= 16'h0000;
			startEventCount <= 16'h0000;
			tripEventCount <= 16'h0000;
			recValid <= 1'b0;
			recVolt <= 16'h0000;
			recPct <= 7'h00;
		end else begin
			recValid <= 1'b0;
			// (RULE9) counters, set wins
			startEventCount <= (clrCnt ? 16'h0000 : startEventCount) + {15'h0000, incStart};
			tripEventCount <= (clrCnt ? 16'h0000 : tripEventCount) + {15'h0000, incTrip};
			if (start && level > peak) begin
				peak <= level;
			end
			case (state)
				ST_IDLE: begin
					// (RULE11) blocked status
					if (blocked) begin
						state <= ST_BLOCKED;
					// (RULE2) pick up start
					end else if (pick) begin
						state <= ST_STARTED;
						elapsed <= 16'h0000;
						peak <= level;
					end
				end
				ST_BLOCKED: begin
					if (!blocked) begin
						state <= ST_IDLE;
					end
				end
				ST_STARTED: begin
					if (blocked || !pick) begin
						// (RULE15) drop and rearm
						state <= blocked ? ST_BLOCKED : ST_IDLE;
						recValid <= 1'b1;
						recVolt <= peak;
						// (RULE13) elapsed percent
						recPct <= pctNow;
					// (RULE3) definite time trip
					end else if (incTrip) begin
						state <= ST_TRIPPED;
					end else if (msTick && elapsed != 16'hffff) begin
						elapsed <= elapsed + 16'h0001;
					end
				end
				ST_TRIPPED: begin
					if (blocked || !pick) begin
						state <= blocked ? ST_BLOCKED : ST_IDLE;
						recValid <= 1'b1;
						recVolt <= peak;
						recPct <= `ROV_TRIP_PCT;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule // rov_stage

// [tb/rov_asserts.sv]
// port checker of the residual overvoltage block
`timescale 1ns/1ps
module rov_asserts #(
	parameter MS_CYCLES = 10,
	parameter FORCE_TIMEOUT_MS = 5
) (
	input wire mclk,
	input wire srst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	input wire blockLow,
	input wire startLow,
	input wire tripLow,
	input wire startHigh,
	input wire tripHigh,
	input wire forceFlag
);
	localparam int LIMIT = (FORCE_TIMEOUT_MS + 1) * MS_CYCLES + 4;
	logic ctrlPh;
	int forceAge;
	wire take = hsel && hready && htrans[1];
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	// control write data phase and force age
	always @(posedge mclk) begin
		if (srst)
			ctrlPh <= 1'b0;
		else if (hready)
			ctrlPh <= take && hwrite && haddr[11:2] == 10'h000;
		if (srst || !forceFlag || ctrlPh)
			forceAge <= 0;
		else
			forceAge <= forceAge + 1;
	end
	bus_ready_a: assert property (hreadyout) else $error("hreadyout low");
	bus_okay_a: assert property (!hresp) else $error("error response");
	read_hold_a: assert property (!(take && !hwrite) |=> $stable(hrdata))
		else $error("read data changed without a read");
	force_set_a: assert property ($rose(forceFlag) |-> $past(ctrlPh) && $past(hwdata[1]))
		else $error("force flag set without a control write");
	force_timeout_a: assert property (forceAge <= LIMIT)
		else $error("force flag outlived its timeout");
	trip_low_a: assert property (tripLow |-> startLow)
		else $error("low trip without start");
	trip_high_a: assert property (tripHigh |-> startHigh)
		else $error("high trip without start");
	trip_delay_a: assert property ($rose(tripLow) && !$past(forceFlag) |->
		$past(startLow) && $past(startLow, 2)) else $error("trip with no start before");
	block_low_a: assert property ((blockLow && !forceFlag)[*3] |-> !startLow && !tripLow)
		else $error("blocked stage active");
	cover property ($rose(tripLow));
	cover property ($rose(startLow) && blockLow == 1'b0);
	cover property ($fell(forceFlag));
endmodule // rov_asserts
bind rov_top rov_asserts #(.MS_CYCLES(MS_CYCLES), .FORCE_TIMEOUT_MS(FORCE_TIMEOUT_MS)) chk (
	.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.blockLow(blockLow), .startLow(startLow), .tripLow(tripLow), .startHigh(startHigh),
	.tripHigh(tripHigh), .forceFlag(forceFlag));

// [tb/rov_front_model.sv]
// front end model: balanced phases plus a residual wave of chosen harmonic
`timescale 1ns/1ps
module rov_front_model (
	input wire mclk,
	input wire [15:0] amp,
	input wire [2:0] harm,
	input wire toPhases,
	output logic sampleValid,
	output logic [15:0] sampleA,
	output logic [15:0] sampleB,
	output logic [15:0] sampleC,
	output logic [15:0] sampleRes
);
	logic [5:0] ph = 6'h00;
	real w;
	real z;
	real p;
	initial begin
		sampleValid = 1'b0;
		{sampleA, sampleB, sampleC, sampleRes} = 64'h0;
	end
	// one sample every four clocks, sixteen per power cycle
	always @(posedge mclk) begin
		ph <= ph + 6'h01;
		w = 6.283185 * ph[5:2] / 16.0;
		z = $signed(amp) * $sin(w * harm);
		p = toPhases ? z : 0.0;
		sampleValid <= ph[1:0] == 2'b11;
		if (ph[1:0] == 2'b11) begin
			sampleA <= 16'($rtoi(p + 8000.0 * $sin(w)));
			sampleB <= 16'($rtoi(p + 8000.0 * $sin(w - 2.094395)));
			sampleC <= 16'($rtoi(p + 8000.0 * $sin(w + 2.094395)));
			sampleRes <= 16'($rtoi(toPhases ? 0.0 : z));
		end else begin
			// lines are not held between samples
			{sampleA, sampleB, sampleC, sampleRes} <= ~{sampleA, sampleB, sampleC, sampleRes};
		end
	end
endmodule // rov_front_model

// [tb/tb_residual_overvoltage_stages.sv]
// self-checking bench of the residual overvoltage stages
`timescale 1ns/1ps
module tb_residual_overvoltage_stages;
	localparam int MS = 10;
	localparam logic [31:0] CTL = 32'h0;
	localparam logic [31:0] ST = 32'h40;
	localparam logic [31:0] CLO = 32'h44;
	localparam logic [31:0] REC = 32'h80;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'b010;
	logic [31:0] hwdata = 32'h0;
	logic [15:0] amp = 16'h0;
	logic [2:0] harm = 3'h1;
	logic toPh = 1'b0;
	logic srcOn = 1'b0;
	logic blockLow = 1'b0;
	logic [31:0] rtcDate = 32'h1234_5678;
	wire hreadyout, sampleValid, startLow, tripLow, startHigh, tripHigh, forceFlag;
	wire [31:0] hrdata;
	wire [15:0] sampleA, sampleB, sampleC, sampleRes;
	wire [3:0] outs = {startLow, tripLow, startHigh, tripHigh};
	int failCount = 0;
	int nCompared = 0;
	rov_front_model fe (.mclk, .amp, .harm, .toPhases(toPh), .sampleValid, .sampleA, .sampleB,
		.sampleC, .sampleRes);
	rov_top #(.MS_CYCLES(MS), .FORCE_TIMEOUT_MS(5)) dut (.mclk, .srst, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata,
		.sampleValid, .sampleA, .sampleB, .sampleC, .sampleRes, .digitalIn(8'(srcOn) << 1),
		.virtualInputN(8'(srcOn) << 2), .indicatorSignalN(8'(srcOn) << 3),
		.virtualOutputN(8'(srcOn) << 4), .functionKeyN(8'(srcOn) << 5), .blockLow,
		.blockHigh(1'b0), .rtcDate, .rtcMsOfDay(32'h0000_0400), .startLow, .tripLow,
		.startHigh, .tripHigh, .forceFlag);
	initial begin
		forever #2 mclk = ~mclk;
	end
	task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		r = hrdata;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] t;
		xfer(1'b1, a, d, t);
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] r);
		xfer(1'b0, a, 32'h0, r);
	endtask
	task automatic check(input logic [31:0] seen, exp);
		nCompared++;
		if (seen !== exp) begin
			failCount++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic waitOut(input logic [3:0] mask, val, output int n);
		n = 0;
		while ((outs & mask) !== val && n < 3000) begin
			@(posedge mclk);
			n++;
		end
	endtask
	task automatic conclude;
		$display("compared %0d, mismatches %0d", nCompared, failCount);
		if (failCount == 0 && nCompared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		failCount++;
		$display("watchdog expired");
		conclude();
	end
	initial begin
		logic [31:0] r;
		int n;
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		repeat (2) @(posedge mclk);
		rd(ST, r);
		check(r, 32'h0011_0000);
		rd(32'h8, r);
		check(r, 32'h100);
		wr(32'hfc, 32'hffff_ffff);
		rd(32'hfc, r);
		check(r, 32'h0);
		wr(32'h4, 32'hffff);
		wr(32'h8, 32'hffff);
		wr(32'h20, 32'h0028_0100);
		wr(32'h30, 32'h0001_ffff);
		amp <= 16'd12000;
		waitOut(4'b1000, 4'b1000, n);
		check(32'(outs), 32'h8);
		repeat (5 * MS) @(posedge mclk);
		amp <= 16'h0;
		waitOut(4'b1100, 4'b0000, n);
		check(32'(outs), 32'h0);
		amp <= 16'd12000;
		waitOut(4'b1000, 4'b1000, n);
		waitOut(4'b0100, 4'b0100, n);
		check(32'(n >= 40 * MS + 2 && n <= 41 * MS + 1), 32'h1);
		rd(ST, r);
		check(32'(r[23:16]), 32'h18);
		amp <= 16'h0;
		waitOut(4'b1100, 4'b0000, n);
		rd(CLO, r);
		check(r, 32'h0001_0002);
		wr(REC, 32'h0);
		@(posedge mclk);
		rd(REC, r);
		check(32'(r[7:4]), 32'h2);
		rd(32'h8c, r);
		check(32'(r[25:16]), 32'h64);
		wr(REC, 32'h1);
		@(posedge mclk);
		rd(32'h8c, r);
		check(32'(r[22:16] < 7'd100), 32'h1);
		rd(32'h84, r);
		check(r, rtcDate);
		harm <= 3'h3;
		amp <= 16'd12000;
		repeat (300) @(posedge mclk);
		check(32'(startLow), 32'h0);
		harm <= 3'h1;
		toPh <= 1'b1;
		repeat (300) @(posedge mclk);
		check(32'(startLow), 32'h0);
		wr(CTL, 32'h1);
		waitOut(4'b1000, 4'b1000, n);
		check(32'(outs), 32'h8);
		amp <= 16'h0;
		toPh <= 1'b0;
		wr(CTL, 32'h0);
		waitOut(4'b1100, 4'b0000, n);
		for (int s = 1; s < 6; s++) begin
			for (int j = 0; j < 2; j++) begin
				srcOn <= j == 0;
				wr(CTL, 32'((s << 4) | (s << 8) | 32'h4000));
				rd(ST, r);
				check(32'(r[25:24]), 32'(1 - j));
			end
		end
		wr(CTL, 32'h6000);
		rd(ST, r);
		check(32'(r[25:24]), 32'h2);
		wr(CTL, 32'h0009_0002);
		repeat (3) @(posedge mclk);
		check(32'({forceFlag, startLow, tripHigh}), 32'h7);
		n = 0;
		while (forceFlag !== 1'b0 && n < 1000) begin
			@(posedge mclk);
			n++;
		end
		@(posedge mclk);
		check(32'(n >= 3 * MS && n <= 7 * MS && startLow === 1'b0), 32'h1);
		blockLow <= 1'b1;
		amp <= 16'd12000;
		repeat (300) @(posedge mclk);
		rd(ST, r);
		check(32'({r[19:16], startLow}), 32'h4);
		blockLow <= 1'b0;
		waitOut(4'b1000, 4'b1000, n);
		check(32'(outs), 32'h8);
		amp <= 16'h0;
		waitOut(4'b1100, 4'b0000, n);
		wr(CTL, 32'hc);
		rd(CLO, r);
		check(r, 32'h0);
		rd(32'h48, r);
		check(r, 32'h0);
		conclude();
	end
endmodule // tb_residual_overvoltage_stages
